// *** src/encoder_interface_pkg.sv ***
// constants shared by the encoder interface block and its bench
// assumes a 32-bit apb slave with 8-bit byte addressing
package encoder_interface_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FILT = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_MAXCNT = 8'h0C;
  localparam logic [7:0] OFF_MARKCAP = 8'h10;
  localparam logic [7:0] OFF_STRBCAP = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_LT_PER = 8'h1C;
  localparam logic [7:0] OFF_LT_SCALE = 8'h20;
  localparam logic [7:0] OFF_LT_CNT = 8'h24;
  localparam logic [7:0] OFF_EVT_NUM = 8'h28;
  localparam logic [7:0] OFF_EVT_TIME = 8'h2C;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_MODE_LSB = 0; // two bits
  localparam int CTRL_FREQDIR = 2;
  localparam int CTRL_MEDGE = 3;
  localparam int CTRL_SEDGE = 4;
  localparam int CTRL_LT_EN = 5;
  localparam int STAT_ERR = 0;
  localparam int STAT_A = 1;
  localparam int STAT_B = 2;
  localparam int STAT_SMDONE = 3;
  localparam int STAT_DIR = 4;
  localparam int IN_A = 0;
  localparam int IN_B = 1;
  localparam int IN_Z = 2;
  localparam int IN_S = 3;
  // ****************************************
  // modes, widths and reset values
  // ****************************************
  localparam logic [1:0] MODE_MAXCNT = 2'h0;
  localparam logic [1:0] MODE_MARKER = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam int FILT_W = 4;
  localparam int EVT_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] MAXCNT_RST = 32'hFFFF_FFFF;
  localparam logic [15:0] LT_PER_RST = 16'hFFFF;
  localparam logic [15:0] LT_SCALE_RST = 16'h0000;
endpackage : encoder_interface_pkg

// *** src/encoder_interface.sv ***
// quadrature encoder interface: filters, position counter, captures,
// error monitor, loop timer and pulse interval timer behind apb
// assumes encoder pins are asynchronous to pclk
// ****************************************
// Summary of operation
// - 32-bit up/down counter stepped by quadrature
// - noise filter on all four encoder inputs
// - optional frequency and direction input mode
// - marker or strobe event copies counter
// - capture on rising, or direction-dependent edge
// - registration pulse for each capture input
// - count read latches channel input states
// - everything runs from the peripheral clock
// - marker mode resets counter each pulse
// - maximum count mode wraps at programmed limit
// - single marker mode resets only once
// - count error sets status and interrupt
// - 16-bit auto-reloading loop timer with prescale
// - loop timer timeout raises interrupt pulse
// - interval timer spans up to 255 pulses
// ****************************************
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module encoder_interface (
  input wire logic pclk, // peripheral clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic enc_chan_a_in, // channel a or frequency
  input wire logic enc_chan_b_in, // channel b or direction
  input wire logic index_marker_in, // marker pin
  input wire logic strobe_capture_in, // strobe pin
  output logic marker_irq, // marker capture pulse
  output logic strobe_irq, // strobe capture pulse
  output logic count_err_irq, // count error pulse
  output logic loop_timer_irq // loop timer timeout pulse
);
  localparam int FW = encoder_interface_pkg::FILT_W;
  localparam int EW = encoder_interface_pkg::EVT_W;
  typedef struct packed {
    logic [3:0][1:0] sync;
    logic [3:0] filt;
    logic [3:0][FW-1:0] fcnt;
    logic [FW-1:0] flen;
    logic [7:0] ctrl;
    logic [31:0] count;
    logic [31:0] position_max_count;
    logic [31:0] marker_capture_value;
    logic [31:0] strobe_capture_value;
    logic err;
    logic a_lat;
    logic b_lat;
    logic smdone;
    logic dir;
    logic [15:0] lt_per;
    logic [15:0] lt_scale;
    logic [15:0] lt_cnt;
    logic [15:0] lt_pre;
    logic [EW-1:0] evt_num;
    logic [EW-1:0] evt_pulses;
    logic [31:0] evt_run;
    logic [31:0] evt_time;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mirq;
    logic sirq;
    logic eirq;
    logic lirq;
  } state_t;
  state_t s_reg;
  state_t s_next;
  logic step_up;
  logic step_dn;
  logic both_chg;
  logic mark_ev;
  logic strb_ev;
  logic wr_en;
  logic rd_en;
  // ****************************************
  // helpers
  // ****************************************
  // capture qualification: rising only, or edge chosen by direction
  function automatic logic qual_edge(input logic old_v, input logic new_v,
                                     input logic dir_mode, input logic fwd);
    logic rise;
    logic fall;
    rise = ~old_v & new_v;
    fall = old_v & ~new_v;
    qual_edge = dir_mode ? (fwd ? rise : fall) : rise;
  endfunction : qual_edge
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [1:0] mode;
    logic setup;
    logic acc;
    logic [3:0] pins;
    s_next = s_reg;
    mode = s_reg.ctrl[encoder_interface_pkg::CTRL_MODE_LSB +: 2];
    setup = psel & ~penable;
    acc = psel & penable & s_reg.pready;
    pins = {strobe_capture_in, index_marker_in, enc_chan_b_in, enc_chan_a_in};
    s_next.mirq = 1'b0;
    s_next.sirq = 1'b0;
    s_next.eirq = 1'b0;
    s_next.lirq = 1'b0;

    // two-stage sync then stability filter; stage one feeds stage two only
    for (int i = 0; i < 4; i++) begin
      s_next.sync[i] = {s_reg.sync[i][0], pins[i]};
      if (s_reg.sync[i][1] != s_reg.filt[i]) begin
        if (s_reg.fcnt[i] >= s_reg.flen) begin
          s_next.filt[i] = s_reg.sync[i][1];
          s_next.fcnt[i] = '0;
        end else begin
          s_next.fcnt[i] = s_reg.fcnt[i] + FW'(1);
        end
      end else begin
        s_next.fcnt[i] = '0; // a glitch shorter than flen is dropped
      end
    end
    // decode: quadrature, or frequency plus direction
    both_chg = 1'b0;
    step_up = 1'b0;
    step_dn = 1'b0;
    if (s_reg.ctrl[encoder_interface_pkg::CTRL_FREQDIR]) begin
      if (~s_reg.filt[encoder_interface_pkg::IN_A] &
          s_next.filt[encoder_interface_pkg::IN_A]) begin
        step_up = s_reg.filt[encoder_interface_pkg::IN_B];
        step_dn = ~s_reg.filt[encoder_interface_pkg::IN_B];
      end
    end else begin
      case ({s_next.filt[1:0] != s_reg.filt[1:0]} ? (s_next.filt[1:0] ^ s_reg.filt[1:0]) : 2'b00)
        2'b11: both_chg = 1'b1;
        2'b01, 2'b10: begin
          // up when previous a equals new b, i.e. a leads
          step_up = (s_reg.filt[0] == s_next.filt[1]);
          step_dn = (s_reg.filt[0] != s_next.filt[1]);
        end
        default: ;
      endcase
    end
    mark_ev = qual_edge(s_reg.filt[encoder_interface_pkg::IN_Z],
                        s_next.filt[encoder_interface_pkg::IN_Z],
                        s_reg.ctrl[encoder_interface_pkg::CTRL_MEDGE], s_reg.dir);
    strb_ev = qual_edge(s_reg.filt[encoder_interface_pkg::IN_S],
                        s_next.filt[encoder_interface_pkg::IN_S],
                        s_reg.ctrl[encoder_interface_pkg::CTRL_SEDGE], s_reg.dir);
    // position counter; plain wrap outside max count mode
    if (step_up) begin
      s_next.dir = 1'b1;
      if (mode == encoder_interface_pkg::MODE_MAXCNT &&
          s_reg.count == s_reg.position_max_count)
        s_next.count = '0;
      else
        s_next.count = s_reg.count + 32'h0000_0001;
    end else if (step_dn) begin
      s_next.dir = 1'b0;
      if (mode == encoder_interface_pkg::MODE_MAXCNT && s_reg.count == '0)
        s_next.count = s_reg.position_max_count;
      else
        s_next.count = s_reg.count - 32'h0000_0001;
    end
    if (mark_ev && mode == encoder_interface_pkg::MODE_MARKER)
      s_next.count = '0;
    if (mark_ev && mode == encoder_interface_pkg::MODE_SINGLE && !s_reg.smdone) begin
      s_next.count = '0;
      s_next.smdone = 1'b1;
    end
    // captures take the count as it stood before this edge
    if (mark_ev) begin
      s_next.marker_capture_value = s_reg.count;
      s_next.mirq = 1'b1;
    end
    if (strb_ev) begin
      s_next.strobe_capture_value = s_reg.count;
      s_next.sirq = 1'b1;
    end
    // loop timer: prescale divides pclk, counter reloads from period
    if (s_reg.ctrl[encoder_interface_pkg::CTRL_LT_EN]) begin
      if (s_reg.lt_pre >= s_reg.lt_scale) begin
        s_next.lt_pre = '0;
        if (s_reg.lt_cnt == '0) begin
          s_next.lt_cnt = s_reg.lt_per;
          s_next.lirq = 1'b1;
        end else begin
          s_next.lt_cnt = s_reg.lt_cnt - 16'h0001;
        end
      end else begin
        s_next.lt_pre = s_reg.lt_pre + 16'h0001;
      end
    end else begin
      s_next.lt_pre = '0;
      s_next.lt_cnt = s_reg.lt_per;
    end
    // interval timer; saturates so an interval too long for the counter is captured as max time
    if (s_reg.evt_run != 32'hFFFF_FFFF)
      s_next.evt_run = s_reg.evt_run + 32'h0000_0001;
    if ((step_up | step_dn) && s_reg.evt_num != '0) begin
      if (s_reg.evt_pulses + EW'(1) >= s_reg.evt_num) begin
        s_next.evt_time = s_reg.evt_run;
        s_next.evt_run = 32'h0000_0001;
        s_next.evt_pulses = '0;
      end else begin
        s_next.evt_pulses = s_reg.evt_pulses + EW'(1);
      end
    end
    // ****************************************
    // apb slave: zero wait states, data prepared in setup
    // ****************************************
    s_next.pready = setup;
    wr_en = acc & pwrite & ~s_reg.pslverr;
    rd_en = acc & ~pwrite & ~s_reg.pslverr;
    if (setup) begin
      s_next.pslverr = 1'b0;
      unique case (paddr)
        encoder_interface_pkg::OFF_CTRL: s_next.prdata = 32'(s_reg.ctrl);
        encoder_interface_pkg::OFF_FILT: s_next.prdata = 32'(s_reg.flen);
        encoder_interface_pkg::OFF_COUNT: s_next.prdata = s_reg.count;
        encoder_interface_pkg::OFF_MAXCNT: s_next.prdata = s_reg.position_max_count;
        encoder_interface_pkg::OFF_MARKCAP: s_next.prdata = s_reg.marker_capture_value;
        encoder_interface_pkg::OFF_STRBCAP: s_next.prdata = s_reg.strobe_capture_value;
        encoder_interface_pkg::OFF_STATUS:
          s_next.prdata = 32'({s_reg.dir, s_reg.smdone, s_reg.b_lat, s_reg.a_lat, s_reg.err});
        encoder_interface_pkg::OFF_LT_PER: s_next.prdata = 32'(s_reg.lt_per);
        encoder_interface_pkg::OFF_LT_SCALE: s_next.prdata = 32'(s_reg.lt_scale);
        encoder_interface_pkg::OFF_LT_CNT: s_next.prdata = 32'(s_reg.lt_cnt);
        encoder_interface_pkg::OFF_EVT_NUM: s_next.prdata = 32'(s_reg.evt_num);
        encoder_interface_pkg::OFF_EVT_TIME: s_next.prdata = s_reg.evt_time;
        default: begin
          s_next.prdata = '0;
          s_next.pslverr = 1'b1;
        end
      endcase
    end
    if (rd_en && paddr == encoder_interface_pkg::OFF_COUNT) begin
      s_next.a_lat = s_reg.filt[encoder_interface_pkg::IN_A];
      s_next.b_lat = s_reg.filt[encoder_interface_pkg::IN_B];
    end
    if (wr_en) begin
      unique case (paddr)
        encoder_interface_pkg::OFF_CTRL: begin
          s_next.ctrl = pwdata[7:0];
          s_next.smdone = s_next.smdone & ~s_reg.smdone; // rearm; a same-cycle set wins
        end
        encoder_interface_pkg::OFF_FILT: s_next.flen = pwdata[FW-1:0];
        encoder_interface_pkg::OFF_COUNT: s_next.count = pwdata; // software wins
        encoder_interface_pkg::OFF_MAXCNT: s_next.position_max_count = pwdata;
        encoder_interface_pkg::OFF_STATUS:
          if (pwdata[encoder_interface_pkg::STAT_ERR]) s_next.err = 1'b0;
        encoder_interface_pkg::OFF_LT_PER: s_next.lt_per = pwdata[15:0];
        encoder_interface_pkg::OFF_LT_SCALE: s_next.lt_scale = pwdata[15:0];
        encoder_interface_pkg::OFF_EVT_NUM: begin
          s_next.evt_num = pwdata[EW-1:0];
          s_next.evt_pulses = '0;
        end
        default: ;
      endcase
    end
    // error set after the clear so a same-cycle event is kept
    if (both_chg) begin
      s_next.err = 1'b1;
      s_next.eirq = 1'b1;
    end
  end
  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= encoder_interface_pkg::CTRL_RST;
      s_reg.position_max_count <= encoder_interface_pkg::MAXCNT_RST;
      s_reg.lt_per <= encoder_interface_pkg::LT_PER_RST;
      s_reg.lt_cnt <= encoder_interface_pkg::LT_PER_RST;
      s_reg.lt_scale <= encoder_interface_pkg::LT_SCALE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign marker_irq = s_reg.mirq;
  assign strobe_irq = s_reg.sirq;
  assign count_err_irq = s_reg.eirq;
  assign loop_timer_irq = s_reg.lirq;
  // ****************************************
  // checks
  // ****************************************
  property p_filter_stable;
    @(posedge pclk) disable iff (!presetn)
      $changed(s_reg.filt[0]) |-> $past(s_reg.fcnt[0]) >= $past(s_reg.flen) &&
      $past(s_reg.sync[0][1]) == s_reg.filt[0];
  endproperty
  a_filter_stable: assert property (p_filter_stable)
    else $error("filter changed without stable input");
  property p_mark_cap;
    @(posedge pclk) disable iff (!presetn)
      mark_ev |=> s_reg.mirq && s_reg.marker_capture_value == $past(s_reg.count);
  endproperty
  a_mark_cap: assert property (p_mark_cap)
    else $error("marker capture wrong");
  property p_strb_cap;
    @(posedge pclk) disable iff (!presetn)
      strb_ev |=> s_reg.sirq ##1 !s_reg.sirq || $past(strb_ev);
  endproperty
  a_strb_cap: assert property (p_strb_cap)
    else $error("strobe pulse wrong");
  property p_step_up;
    @(posedge pclk) disable iff (!presetn)
      step_up && !wr_en && !mark_ev && s_reg.count != s_reg.position_max_count
      |=> s_reg.count == $past(s_reg.count) + 32'h0000_0001;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("count did not step up");
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      step_up && !wr_en && !mark_ev && s_reg.count == s_reg.position_max_count &&
      s_reg.ctrl[1:0] == encoder_interface_pkg::MODE_MAXCNT |=> s_reg.count == '0;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("max count wrap failed");
  property p_both;
    @(posedge pclk) disable iff (!presetn)
      both_chg && !wr_en && !mark_ev
      |=> s_reg.err && s_reg.eirq && $stable(s_reg.count);
  endproperty
  a_both: assert property (p_both)
    else $error("double change not flagged");
  property p_single;
    @(posedge pclk) disable iff (!presetn)
      s_reg.smdone && mark_ev && !wr_en && !step_up && !step_dn
      |=> $stable(s_reg.count);
  endproperty
  a_single: assert property (p_single)
    else $error("second marker reset counter");
  property p_loop;
    @(posedge pclk) disable iff (!presetn)
      s_reg.lirq |-> s_reg.lt_cnt == s_reg.lt_per && !$past(s_reg.lirq);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop timer reload wrong");
  property p_ab_latch;
    @(posedge pclk) disable iff (!presetn)
      rd_en && paddr == encoder_interface_pkg::OFF_COUNT
      |=> s_reg.a_lat == $past(s_reg.filt[0]) && s_reg.b_lat == $past(s_reg.filt[1]);
  endproperty
  a_ab_latch: assert property (p_ab_latch)
    else $error("channel state not latched on read");
endmodule : encoder_interface

// *** dv/quad_encoder_model.sv ***
// behavioural incremental shaft encoder: two channels, marker and strobe
// assumes the bench calls its tasks; pins change only just after a pclk edge
`timescale 1ns/1ps
module quad_encoder_model #(
  parameter int GAP = 10 // cycles each pin change is held
) (
  input wire logic pclk, // pacing clock
  output logic chan_a, // channel a or frequency
  output logic chan_b, // channel b or direction
  output logic marker, // marker pin
  output logic strobe // strobe pin
);
  // ****************************************
  // pin drivers
  // ****************************************
  // all lines are push-pull, so an idle line keeps its level
  initial begin
    chan_a = 1'b0;
    chan_b = 1'b0;
    marker = 1'b0;
    strobe = 1'b0;
  end

  // set both channels, then hold them; a short hold makes a glitch
  task automatic put(input logic a, input logic b, input int n);
    @(posedge pclk);
    chan_a <= a;
    chan_b <= b;
    repeat (n) @(posedge pclk);
  endtask : put

  // one quadrature edge; forward keeps a leading b
  task automatic step(input logic up);
    if (up) begin
      put(~chan_b, chan_a, GAP);
    end else begin
      put(chan_b, ~chan_a, GAP);
    end
  endtask : step

  // marker pulse, long enough to pass any filter length used
  task automatic mark_pulse();
    @(posedge pclk);
    marker <= 1'b1;
    repeat (GAP) @(posedge pclk);
    marker <= 1'b0;
    repeat (GAP) @(posedge pclk);
  endtask : mark_pulse

  // strobe level change, then hold
  task automatic set_strobe(input logic v);
    @(posedge pclk);
    strobe <= v;
    repeat (GAP) @(posedge pclk);
  endtask : set_strobe
endmodule : quad_encoder_model

// *** dv/tb.sv ***
// self-checking bench for the encoder interface, apb register tasks
// assumes the encoder model sits on the four encoder pins
`timescale 1ns/1ps
module tb;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic enc_chan_a_in;
  logic enc_chan_b_in;
  logic index_marker_in;
  logic strobe_capture_in;
  logic marker_irq;
  logic strobe_irq;
  logic count_err_irq;
  logic loop_timer_irq;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n_mirq = 0;
  int n_sirq = 0;
  int n_cerr = 0;
  int lt_n = 0;
  int lt_last = 0;
  int lt_prev = 0;
  int n0;
  logic [31:0] d;
  logic e;

  always #12.5 pclk = ~pclk;

  encoder_interface dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_chan_a_in(enc_chan_a_in), .enc_chan_b_in(enc_chan_b_in),
    .index_marker_in(index_marker_in), .strobe_capture_in(strobe_capture_in),
    .marker_irq(marker_irq), .strobe_irq(strobe_irq), .count_err_irq(count_err_irq),
    .loop_timer_irq(loop_timer_irq));

  quad_encoder_model #(.GAP(10)) enc_u (.pclk(pclk), .chan_a(enc_chan_a_in),
    .chan_b(enc_chan_b_in), .marker(index_marker_in), .strobe(strobe_capture_in));

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one apb transfer; waits for pready under a bound, takes data at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic err);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 16);
    rd_data = prdata;
    err = pslverr;
    check({31'h0, pready}, 32'h0000_0001, "ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, wd, x, y);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input string what);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0000_0000, x, y);
    check(x & m, exp, what);
    check({31'h0, y}, 32'h0000_0000, "slverr on mapped read");
  endtask : rd

  // irq pulse counters, loop timer spacing and the run ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (marker_irq === 1'b1) n_mirq <= n_mirq + 1;
    if (strobe_irq === 1'b1) n_sirq <= n_sirq + 1;
    if (count_err_irq === 1'b1) n_cerr <= n_cerr + 1;
    if (loop_timer_irq === 1'b1) begin
      lt_prev <= lt_last;
      lt_last <= cyc;
      lt_n <= lt_n + 1;
    end
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(encoder_interface_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000, "ctrl rst");
    rd(encoder_interface_pkg::OFF_MAXCNT, 32'hFFFF_FFFF, 32'hFFFF_FFFF, "maxcnt rst");
    rd(encoder_interface_pkg::OFF_LT_PER, 32'hFFFF_FFFF, 32'h0000_FFFF, "per rst");
    rd(encoder_interface_pkg::OFF_LT_CNT, 32'hFFFF_FFFF, 32'h0000_FFFF, "lt rst");
    apb(1'b0, 8'h30, 32'h0000_0000, d, e);
    check({31'h0, e}, 32'h0000_0001, "unmapped err");
    check(d, 32'h0000_0000, "unmapped data");
    // quadrature both ways, then pin states latched by the count read
    repeat (8) enc_u.step(1'b1);
    repeat (3) enc_u.step(1'b0);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0005, "quad");
    rd(encoder_interface_pkg::OFF_STATUS, 32'h0000_0016,
       {27'h0, 2'b00, enc_chan_b_in, enc_chan_a_in, 1'b0}, "pins");
    // both channels at once is an error without a step
    n0 = n_cerr;
    enc_u.put(~enc_chan_a_in, ~enc_chan_b_in, 10);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0005, "no step");
    rd(encoder_interface_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "err");
    check(32'(n_cerr - n0), 32'h0000_0001, "err irq");
    wr(encoder_interface_pkg::OFF_STATUS, 32'h0000_0001);
    rd(encoder_interface_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "err clr");
    // maximum count wrap both ways
    wr(encoder_interface_pkg::OFF_MAXCNT, 32'h0000_0003);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_0003);
    enc_u.step(1'b1);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0000, "wrap up");
    enc_u.step(1'b0);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0003, "wrap dn");
    wr(encoder_interface_pkg::OFF_MAXCNT, 32'hFFFF_FFFF);
    // marker resets on every pulse; edge follows direction (falling first, then rising)
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0009);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_000A);
    n0 = n_mirq;
    enc_u.mark_pulse();
    rd(encoder_interface_pkg::OFF_MARKCAP, 32'hFFFF_FFFF, 32'h0000_000A, "mcap");
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0000, "mrst");
    check(32'(n_mirq - n0), 32'h0000_0001, "marker irq");
    enc_u.step(1'b1);
    enc_u.mark_pulse();
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0000, "mrst2");
    // single marker resets only once
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0002);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_0007);
    enc_u.mark_pulse();
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0000, "single1");
    repeat (2) enc_u.step(1'b1);
    enc_u.mark_pulse();
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0002, "single2");
    rd(encoder_interface_pkg::OFF_MARKCAP, 32'hFFFF_FFFF, 32'h0000_0002, "mcap2");
    rd(encoder_interface_pkg::OFF_STATUS, 32'h0000_0008, 32'h0000_0008, "sdone");
    // strobe on falling edge while reversing
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0010);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_0014);
    enc_u.step(1'b0);
    n0 = n_sirq;
    enc_u.set_strobe(1'b1);
    rd(encoder_interface_pkg::OFF_STRBCAP, 32'hFFFF_FFFF, 32'h0000_0000, "no rise");
    enc_u.set_strobe(1'b0);
    rd(encoder_interface_pkg::OFF_STRBCAP, 32'hFFFF_FFFF, 32'h0000_0013, "fall");
    check(32'(n_sirq - n0), 32'h0000_0001, "strobe irq");
    // frequency and direction: three up, one down
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0004);
    enc_u.put(1'b0, 1'b1, 10);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_0000);
    repeat (3) begin
      enc_u.put(1'b1, 1'b1, 10);
      enc_u.put(1'b0, 1'b1, 10);
    end
    enc_u.put(1'b0, 1'b0, 10);
    enc_u.put(1'b1, 1'b0, 10);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0002, "freq");
    // filter of four rejects a three-cycle glitch, passes a real edge
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0000);
    wr(encoder_interface_pkg::OFF_FILT, 32'h0000_0004);
    wr(encoder_interface_pkg::OFF_COUNT, 32'h0000_0000);
    enc_u.put(~enc_chan_a_in, enc_chan_b_in, 2);
    enc_u.put(~enc_chan_a_in, enc_chan_b_in, 12);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0000, "glitch");
    enc_u.step(1'b1);
    rd(encoder_interface_pkg::OFF_COUNT, 32'hFFFF_FFFF, 32'h0000_0001, "filt");
    wr(encoder_interface_pkg::OFF_FILT, 32'h0000_0000);
    // interval over two steps spaced eleven cycles
    wr(encoder_interface_pkg::OFF_EVT_NUM, 32'h0000_0002);
    repeat (6) enc_u.step(1'b1);
    apb(1'b0, encoder_interface_pkg::OFF_EVT_TIME, 32'h0000_0000, d, e);
    check({31'h0, (d >= 32'h0000_0014 && d <= 32'h0000_0018)}, 32'h0000_0001, "interval");
    // loop timer period (4+1)*(1+1)
    wr(encoder_interface_pkg::OFF_LT_PER, 32'h0000_0004);
    wr(encoder_interface_pkg::OFF_LT_SCALE, 32'h0000_0001);
    n0 = lt_n;
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0020);
    for (int i = 0; i < 200 && lt_n < n0 + 3; i++) @(posedge pclk);
    check(32'(lt_last - lt_prev), 32'h0000_000A, "lt period");
    wr(encoder_interface_pkg::OFF_CTRL, 32'h0000_0000);
    rd(encoder_interface_pkg::OFF_LT_CNT, 32'hFFFF_FFFF, 32'h0000_0004, "lt off");
    test_done();
  end
endmodule : tb
